// *** vc_regs_pkg.sv ***
package vc_regs_pkg;

   // -------------------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------------------
   localparam logic [11:0] CH0_STATUS_OFFSET = 12'h16a;
   localparam logic [11:0] CH1_CAP_OFFSET    = 12'h16c;

   // -------------------------------------------------------------------------
   // Resource status layout (channel 0)
   // -------------------------------------------------------------------------
   localparam int          STATUS_PENDING_BIT = 1;
   localparam int          STATUS_DIRTY_BIT   = 0;
   localparam logic [15:0] STATUS_RESET       = 16'h0000;

   // -------------------------------------------------------------------------
   // Resource capability layout (channel 1)
   // -------------------------------------------------------------------------
   localparam logic [7:0]  ARB_TABLE_LOCATION      = 8'h07;
   localparam logic [0:0]  CAP_RSVD23              = 1'h0;
   localparam logic [6:0]  MAX_SLOT_COUNT          = 7'h7f;
   localparam logic [0:0]  REJECT_SNOOP_VALUE      = 1'h0;
   localparam logic [0:0]  AS_ONLY_TRAFFIC_VALUE   = 1'h0;
   localparam logic [5:0]  CAP_RSVD13_8            = 6'h00;
   localparam int          SCHEME_FIXED_RR_BIT     = 0;
   localparam int          SCHEME_WRR32_BIT        = 1;
   localparam int          SCHEME_WRR64_BIT        = 2;
   localparam int          SCHEME_WRR128_BIT       = 3;
   localparam int          SCHEME_TB_WRR128_BIT    = 4;
   localparam int          SCHEME_WRR256_BIT       = 5;
   localparam logic [7:0]  ARBITRATION_SCHEME_SUPPORT = 8'h11;
   localparam logic [31:0] CAP_RESET               = 32'h077f0011;

endpackage : vc_regs_pkg

// *** vc_status_capability_regs.sv ***
// Behaviour
// - Bits 15:2 of the channel 0 resource status register always read zero.
// - The negotiation in progress flag is high while VC negotiation runs, at startup or after an enable/disable request.
// - The table dirty flag is set whenever any port arbitration table entry of channel 0 is modified.
// - The table dirty flag clears only once a requested table refresh has finished.
// - The channel 1 capability register is read-only and holds 077F_0011h.
// - The arbitration table location field (31:24) reads 07h, a table 112 bytes into the structure.
// - Capability bit 23 and bits 13:8 read zero.
// - The maximum slot count field (22:16) reads all ones, 128 slots.
// - The snoop rejection bit 15 reads zero.
// - The as-only-traffic bit 14 reads zero.
// - The scheme support byte carries one bit per arbitration scheme, bits 6 and 7 reserved.
// - The scheme support byte reads 11h, fixed round-robin and time-based 128-phase WRR.
// - The channel 0 status register sits at 16Ah, is read-only and resets to zero.
`timescale 1ns/1ps
module vc_status_capability_regs (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Configuration access
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [11:0] cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_hit,
   // Hardware events
   input  wire logic        negotiation_busy,
   input  wire logic        table_entry_write,
   input  wire logic        refresh_done,
   // State
   output logic             negotiation_in_progress_flag,
   output logic             table_dirty_flag
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic        pending;
      logic        dirty;
      logic [31:0] rdata;
      logic        hit;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   logic [31:0] cap_word;
   logic [15:0] status_word;

   always_comb begin
      cap_word = {vc_regs_pkg::ARB_TABLE_LOCATION, vc_regs_pkg::CAP_RSVD23,
                  vc_regs_pkg::MAX_SLOT_COUNT,
                  vc_regs_pkg::REJECT_SNOOP_VALUE,
                  vc_regs_pkg::AS_ONLY_TRAFFIC_VALUE,
                  vc_regs_pkg::CAP_RSVD13_8,
                  vc_regs_pkg::ARBITRATION_SCHEME_SUPPORT};
      status_word = {14'h0000, state_r.pending, state_r.dirty};
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      // Writes are ignored by design; cfg_wr and cfg_wdata steer nothing
      state_nxt.pending = negotiation_busy;
      if (table_entry_write) begin
         state_nxt.dirty = 1'h1;
      end else if (refresh_done) begin
         state_nxt.dirty = 1'h0;
      end
      state_nxt.hit   = 1'h0;
      state_nxt.rdata = 32'h0000_0000;
      if (cfg_rd && cfg_addr == vc_regs_pkg::CH0_STATUS_OFFSET) begin
         state_nxt.hit   = 1'h1;
         state_nxt.rdata = {16'h0000, status_word};
      end else if (cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET) begin
         state_nxt.hit   = 1'h1;
         state_nxt.rdata = cap_word;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= '{pending: 1'h0, dirty: 1'h0, rdata: 32'h0000_0000, hit: 1'h0};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign cfg_rdata                    = state_r.rdata;
   assign cfg_hit                      = state_r.hit;
   assign negotiation_in_progress_flag = state_r.pending;
   assign table_dirty_flag             = state_r.dirty;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   a_status_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH0_STATUS_OFFSET |=> cfg_rdata[31:2] == 30'h0)
      else $error("status reserved bits not zero");
   a_pending_follows: assert property (@(posedge clk) disable iff (!rstn)
      negotiation_busy |=> negotiation_in_progress_flag)
      else $error("pending flag missed negotiation");
   a_dirty_sets: assert property (@(posedge clk) disable iff (!rstn)
      table_entry_write |=> table_dirty_flag)
      else $error("dirty flag not set by table write");
   a_dirty_clears: assert property (@(posedge clk) disable iff (!rstn)
      $fell(table_dirty_flag) |-> $past(refresh_done) && !$past(table_entry_write))
      else $error("dirty flag cleared without refresh");
   a_cap_value: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=> cfg_hit && cfg_rdata == 32'h077f0011)
      else $error("capability value wrong");
   a_cap_location: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=> cfg_rdata[31:24] == 8'h07)
      else $error("table location wrong");
   a_cap_slots: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=> cfg_rdata[23:14] == 10'h1fc)
      else $error("slot count or flag bits wrong");
   a_cap_scheme: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=> cfg_rdata[13:0] == 14'h0011)
      else $error("scheme byte wrong");
   a_write_ignored: assert property (@(posedge clk) disable iff (!rstn)
      cfg_wr && !table_entry_write && !refresh_done |=> $stable(table_dirty_flag))
      else $error("write changed dirty flag");

   // -------------------------------------------------------------------------
   // Assertions: read port
   // -------------------------------------------------------------------------
   a_status_hit: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH0_STATUS_OFFSET |=> cfg_hit)
      else $error("status read missed");
   a_status_flags: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH0_STATUS_OFFSET |=>
      cfg_rdata[1] == $past(negotiation_in_progress_flag) &&
      cfg_rdata[0] == $past(table_dirty_flag))
      else $error("status flags misread");
   a_status_upper: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH0_STATUS_OFFSET |=> cfg_rdata[31:16] == 16'h0000)
      else $error("status upper half not zero");
   a_unmapped_miss: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr != vc_regs_pkg::CH0_STATUS_OFFSET &&
      cfg_addr != vc_regs_pkg::CH1_CAP_OFFSET |=> !cfg_hit && cfg_rdata == 32'h0000_0000)
      else $error("unmapped read answered");
   a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
      !cfg_rd |=> !cfg_hit && cfg_rdata == 32'h0000_0000)
      else $error("read port busy without a read");
   a_hit_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
      cfg_hit && !cfg_rd |=> !cfg_hit)
      else $error("hit stood too long");
   a_write_no_hit: assert property (@(posedge clk) disable iff (!rstn)
      cfg_wr && !cfg_rd |=> !cfg_hit)
      else $error("write produced a hit");

   // -------------------------------------------------------------------------
   // Assertions: status flags
   // -------------------------------------------------------------------------
   a_pending_clears: assert property (@(posedge clk) disable iff (!rstn)
      !negotiation_busy |=> !negotiation_in_progress_flag)
      else $error("pending flag stuck after negotiation");
   a_pending_write: assert property (@(posedge clk) disable iff (!rstn)
      cfg_wr |=> negotiation_in_progress_flag == $past(negotiation_busy))
      else $error("write moved pending flag");
   a_dirty_set_wins: assert property (@(posedge clk) disable iff (!rstn)
      table_entry_write && refresh_done |=> table_dirty_flag)
      else $error("refresh beat a table write");
   a_dirty_cleared: assert property (@(posedge clk) disable iff (!rstn)
      refresh_done && !table_entry_write |=> !table_dirty_flag)
      else $error("dirty flag survived refresh");
   a_dirty_holds: assert property (@(posedge clk) disable iff (!rstn)
      !table_entry_write && !refresh_done |=> $stable(table_dirty_flag))
      else $error("dirty flag moved without an event");
   a_read_keeps_dirty: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && !table_entry_write && !refresh_done |=> $stable(table_dirty_flag))
      else $error("read changed dirty flag");

   // -------------------------------------------------------------------------
   // Assertions: capability fields
   // -------------------------------------------------------------------------
   a_cap_image: assert property (@(posedge clk) disable iff (!rstn)
      cap_word == vc_regs_pkg::CAP_RESET)
      else $error("capability fields disagree with reset value");
   a_cap_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=>
      cfg_rdata[23] == 1'h0 && cfg_rdata[13:8] == 6'h00)
      else $error("capability reserved bits not zero");
   a_cap_slot_ones: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=> cfg_rdata[22:16] == 7'h7f)
      else $error("slot count not all ones");
   a_cap_snoop_zero: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=> cfg_rdata[15] == 1'h0)
      else $error("snoop rejection bit set");
   a_cap_as_only: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=> cfg_rdata[14] == 1'h0)
      else $error("as-only traffic bit set");
   a_scheme_bits: assert property (@(posedge clk) disable iff (!rstn)
      cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=>
      cfg_rdata[vc_regs_pkg::SCHEME_FIXED_RR_BIT] == 1'h1 &&
      cfg_rdata[vc_regs_pkg::SCHEME_TB_WRR128_BIT] == 1'h1 && cfg_rdata[7:6] == 2'h0)
      else $error("scheme support bits wrong");

   // -------------------------------------------------------------------------
   // Assertions: per-bit read images
   // -------------------------------------------------------------------------
   // One check per bit so a failing bit is named by its instance
   for (genvar i = 0; i < 32; i++) begin : g_cap_bits
      a_cap_bit_fixed: assert property (@(posedge clk) disable iff (!rstn)
         cfg_rd && cfg_addr == vc_regs_pkg::CH1_CAP_OFFSET |=>
         cfg_rdata[i] == vc_regs_pkg::CAP_RESET[i])
         else $error("capability bit differs from its fixed value");
   end

   for (genvar i = 2; i < 16; i++) begin : g_status_bits
      a_status_bit_zero: assert property (@(posedge clk) disable iff (!rstn)
         cfg_rd && cfg_addr == vc_regs_pkg::CH0_STATUS_OFFSET |=>
         cfg_rdata[i] == vc_regs_pkg::STATUS_RESET[i])
         else $error("status reserved bit set");
   end

endmodule : vc_status_capability_regs

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic        clk               = 1'h0;
   logic        rstn              = 1'h0;
   logic        cfg_rd            = 1'h0;
   logic        cfg_wr            = 1'h0;
   logic [11:0] cfg_addr          = 12'h000;
   logic [31:0] cfg_wdata         = 32'h00000000;
   logic [31:0] cfg_rdata;
   logic        cfg_hit;
   logic        negotiation_busy  = 1'h0;
   logic        table_entry_write = 1'h0;
   logic        refresh_done      = 1'h0;
   logic        negotiation_in_progress_flag;
   logic        table_dirty_flag;
   int          err_count         = 0;
   int          n_tests           = 0;

   vc_status_capability_regs dut (
      .clk(clk), .rstn(rstn), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
      .negotiation_busy(negotiation_busy), .table_entry_write(table_entry_write),
      .refresh_done(refresh_done), .negotiation_in_progress_flag(negotiation_in_progress_flag),
      .table_dirty_flag(table_dirty_flag));

   always #4 clk = ~clk;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic hit);
      @(negedge clk);
      chk("cfg_hit idle", 32'h0, {31'h0, cfg_hit});
      cfg_rd   = 1'h1;
      cfg_addr = addr;
      @(negedge clk);
      cfg_rd = 1'h0;
      chk("cfg_hit", {31'h0, hit}, {31'h0, cfg_hit});
      chk("cfg_rdata", exp, cfg_rdata);
   endtask : rd

   task automatic wr(input logic [11:0] addr);
      @(negedge clk);
      cfg_wr    = 1'h1;
      cfg_addr  = addr;
      cfg_wdata = 32'hffffffff;
      @(negedge clk);
      cfg_wr = 1'h0;
      chk("cfg_hit on write", 32'h0, {31'h0, cfg_hit});
   endtask : wr

   task automatic ev(input logic w, input logic r, input logic b, input logic dirty);
      @(negedge clk);
      table_entry_write = w;
      refresh_done      = r;
      negotiation_busy  = b;
      @(negedge clk);
      table_entry_write = 1'h0;
      refresh_done      = 1'h0;
      chk("pending flag", {31'h0, b}, {31'h0, negotiation_in_progress_flag});
      chk("dirty flag", {31'h0, dirty}, {31'h0, table_dirty_flag});
   endtask : ev

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // ------------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rstn = 1'h1;
      rd(vc_regs_pkg::CH0_STATUS_OFFSET, 32'h00000000, 1'h1);
      rd(vc_regs_pkg::CH1_CAP_OFFSET, 32'h077f0011, 1'h1);
      rd(12'h168, 32'h00000000, 1'h0);
      rd(12'h16b, 32'h00000000, 1'h0);
      wr(vc_regs_pkg::CH0_STATUS_OFFSET);
      wr(vc_regs_pkg::CH1_CAP_OFFSET);
      rd(vc_regs_pkg::CH1_CAP_OFFSET, 32'h077f0011, 1'h1);
      rd(vc_regs_pkg::CH0_STATUS_OFFSET, 32'h00000000, 1'h1);
      ev(1'h0, 1'h1, 1'h0, 1'h0);
      ev(1'h1, 1'h0, 1'h0, 1'h1);
      rd(vc_regs_pkg::CH0_STATUS_OFFSET, 32'h00000001, 1'h1);
      ev(1'h0, 1'h0, 1'h1, 1'h1);
      rd(vc_regs_pkg::CH0_STATUS_OFFSET, 32'h00000003, 1'h1);
      wr(vc_regs_pkg::CH0_STATUS_OFFSET);
      rd(vc_regs_pkg::CH0_STATUS_OFFSET, 32'h00000003, 1'h1);
      ev(1'h1, 1'h1, 1'h1, 1'h1);
      ev(1'h0, 1'h1, 1'h0, 1'h0);
      rd(vc_regs_pkg::CH0_STATUS_OFFSET, 32'h00000000, 1'h1);
      // Reset in mid-run with both flags set and a read answer standing
      ev(1'h1, 1'h0, 1'h1, 1'h1);
      rd(vc_regs_pkg::CH1_CAP_OFFSET, 32'h077f0011, 1'h1);
      rstn = 1'h0;
      #1;
      chk("rdata in reset", 32'h00000000, cfg_rdata);
      chk("flags in reset", 32'h0,
          {30'h0, negotiation_in_progress_flag, table_dirty_flag});
      @(negedge clk);
      negotiation_busy = 1'h0;
      rstn             = 1'h1;
      rd(vc_regs_pkg::CH0_STATUS_OFFSET, 32'h00000000, 1'h1);
      test_done();
   end

   initial begin
      #20000;
      err_count++;
      test_done();
   end
endmodule : tb_top
